// File: common/eeb_defines.svh
// Shared constants for the two-wire memory slave and its bus master
`ifndef EEB_DEFINES_SVH
`define EEB_DEFINES_SVH
`define EEB_TYPE_ID        4'hA
`define EEB_TYPE_MSB       7
`define EEB_TYPE_LSB       4
`define EEB_STRAP_MSB      3
`define EEB_STRAP_LSB      1
`define EEB_DIR_BIT        0
`define EEB_ADDR_HI_MSB    3
`define EEB_ROWS           128
`define EEB_ROW_BYTES      32
`define EEB_ADDR_W         12
`define EEB_BIT_LAST       3'h7
`define EEB_RECOVER_CLKS   4'h9
`define EEB_PROG_TIME_US   1000
`define EEB_CLK_MHZ        250
`define EEB_PROG_CYCLES    (`EEB_PROG_TIME_US * `EEB_CLK_MHZ)
`define EEB_HALF_DIV       8'h0A
`define EEB_WR_BITS        6'h24
`define EEB_RD_BITS        6'h12
`define EEB_SLOT_BITS      6'h09
`define EEB_ACK_POS        6'h08
`define EEB_RD_NACK_POS    6'h11
`endif

// File: common/eeb_if.sv
// Two-wire link between memory slave and bus master
`timescale 1ns/1ps
`default_nettype none
interface eeb_if;
    logic scl_o;
    logic scl_oe_n;
    logic sda_m_o;
    logic sda_m_oe_n;
    logic sda_s_o;
    logic sda_s_oe_n;
    // Wired-and with pull-ups: low only while someone drives low
    wire  scl_i = !(!scl_oe_n && !scl_o);
    wire  sda_i = !((!sda_m_oe_n && !sda_m_o) || (!sda_s_oe_n && !sda_s_o));
    modport slave (input scl_i, input sda_i, output sda_s_o, output sda_s_oe_n);
    modport master (input scl_i, input sda_i, output scl_o, output scl_oe_n,
                    output sda_m_o, output sda_m_oe_n);
endinterface : eeb_if
`default_nettype wire

// File: common/eeb_pkg.sv
// Types shared by both ends of the two-wire memory link
package eeb_pkg;
    typedef enum logic [2:0] {
        EEB_ST_IDLE = 3'b000,
        EEB_ST_DEV  = 3'b001,
        EEB_ST_AHI  = 3'b010,
        EEB_ST_ALO  = 3'b011,
        EEB_ST_DATA = 3'b100,
        EEB_ST_WAIT = 3'b101,
        EEB_ST_SEND = 3'b110,
        EEB_ST_PROG = 3'b111
    } eeb_state_e;
    typedef enum logic [1:0] {
        EEB_PH_IDLE = 2'b00,
        EEB_PH_BITS = 2'b01,
        EEB_PH_ACK  = 2'b10
    } eeb_phase_e;
endpackage : eeb_pkg

// File: design/eeb_master.sv
// Two-wire bus master: byte write, current read, bus recovery
`timescale 1ns/1ps
`default_nettype none
`include "eeb_defines.svh"
module eeb_master
    import eeb_pkg::*;
#(
    parameter logic [7:0] HALF_DIV = `EEB_HALF_DIV
)(
    input  wire logic        clk_sys_i,
    input  wire logic        resetn_i,
    eeb_if.master            bus,
    input  wire logic        wr_req_i,
    input  wire logic        rd_req_i,
    input  wire logic        recover_req_i,
    input  wire logic [2:0]  strap_i,
    input  wire logic [11:0] addr_i,
    input  wire logic [7:0]  data_i,
    output logic             ready_o,
    output logic             done_o,
    output logic             nack_o,
    output logic [7:0]       rd_data_o
);
    initial
    begin
        if (HALF_DIV < 8'h02)
            $error("HALF_DIV must be at least two");
    end

    // Serial bit list: start, bytes with ack slots, stop
    logic [7:0]  div_r;
    logic [1:0]  q_r;
    logic [5:0]  nbits_r;
    logic [5:0]  idx_r;
    logic [35:0] tx_r;
    logic        run_r;
    logic        stopp_r;
    logic        rec_r;
    logic [3:0]  rec_cnt_r;
    logic        scl_r;
    logic        sda_r;
    logic [7:0]  rx_r;
    logic        nack_r;
    logic        done_r;
    logic [1:0]  sda_s_r;
    logic        is_rd_r;

    wire sda_in = sda_s_r[1];
    wire tick   = (div_r == HALF_DIV - 8'h01);

    // Pin synchroniser for returned data
    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i)
            sda_s_r <= 2'h3;
        else
            sda_s_r <= {sda_s_r[0], bus.sda_i};
    end

    // Divider, bit sequencer and recovery clocking
    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i)
        begin
            div_r <= 8'h00; q_r <= 2'h0; nbits_r <= 6'h00; idx_r <= 6'h00;
            tx_r <= '1; run_r <= 1'b0; stopp_r <= 1'b0; rec_r <= 1'b0;
            rec_cnt_r <= 4'h0; scl_r <= 1'b1; sda_r <= 1'b1; rx_r <= 8'h00;
            nack_r <= 1'b0; done_r <= 1'b0; is_rd_r <= 1'b0;
        end
        else
        begin
            done_r <= 1'b0;
            div_r  <= (run_r || rec_r) && !tick ? div_r + 8'h01 : 8'h00;
            if (!run_r && !rec_r)
            begin
                if (recover_req_i)
                begin
                    rec_r <= 1'b1;
                    rec_cnt_r <= 4'h0;
                end
                else if (wr_req_i || rd_req_i)
                begin
                    // Write: dev, word hi, word lo, data; read: dev then one byte
                    tx_r <= wr_req_i ?
                        {`EEB_TYPE_ID, strap_i, 1'b0, 1'b1, 4'h0, addr_i[11:8], 1'b1,
                         addr_i[7:0], 1'b1, data_i, 1'b1} :
                        {`EEB_TYPE_ID, strap_i, 1'b1, 1'b1, 8'hFF, 1'b1, 18'h3FFFF};
                    nbits_r <= wr_req_i ? `EEB_WR_BITS : `EEB_RD_BITS;
                    is_rd_r <= rd_req_i && !wr_req_i;
                    idx_r <= 6'h00; q_r <= 2'h0; nack_r <= 1'b0;
                    sda_r <= 1'b0;      // Start: data falls with clock high
                    stopp_r <= 1'b0;
                    run_r <= 1'b1;
                end
            end
            else if (rec_r && tick)
            begin
                // Toggle clock until the slave lets data go high, ten at most
                scl_r <= !scl_r;
                if (scl_r && sda_in)
                begin
                    rec_r <= 1'b0; done_r <= 1'b1; scl_r <= 1'b1;  // Clock stays high for a Start
                end
                else if (!scl_r && rec_cnt_r == `EEB_RECOVER_CLKS)
                begin
                    rec_r <= 1'b0; nack_r <= 1'b1; done_r <= 1'b1; scl_r <= 1'b1;
                end
                else if (!scl_r)
                    rec_cnt_r <= rec_cnt_r + 4'h1;
            end
            else if (run_r && tick)
            begin
                q_r <= q_r + 2'h1;
                case (q_r)
                    2'h0: scl_r <= 1'b0;
                    2'h1: sda_r <= stopp_r ? 1'b0 : tx_r[35];
                    2'h2: scl_r <= 1'b1;
                    default:
                    begin
                        if (stopp_r)
                        begin
                            sda_r <= 1'b1;  // Stop: data rises with clock high
                            run_r <= 1'b0; done_r <= 1'b1;
                        end
                        else
                        begin
                            if (idx_r % `EEB_SLOT_BITS == `EEB_ACK_POS)
                            begin
                                if (sda_in && !(is_rd_r && idx_r == `EEB_RD_NACK_POS))
                                begin
                                    nack_r <= 1'b1;
                                    stopp_r <= 1'b1;
                                end
                            end
                            else if (is_rd_r)
                                rx_r <= {rx_r[6:0], sda_in};
                            tx_r  <= {tx_r[34:0], 1'b1};
                            idx_r <= idx_r + 6'h01;
                            if (idx_r == nbits_r - 6'h01)
                                stopp_r <= 1'b1;
                        end
                    end
                endcase
            end
        end
    end

    assign bus.scl_o      = 1'b0;
    assign bus.scl_oe_n   = scl_r;
    assign bus.sda_m_o    = 1'b0;
    assign bus.sda_m_oe_n = sda_r;
    assign ready_o        = !run_r && !rec_r;
    assign done_o         = done_r;
    assign nack_o         = nack_r;
    assign rd_data_o      = rx_r;
endmodule : eeb_master
`default_nettype wire

// File: design/eeb_slave.sv
// Two-wire memory slave: address decode, word address capture, byte write
`timescale 1ns/1ps
`default_nettype none
`include "eeb_defines.svh"
module eeb_slave
    import eeb_pkg::*;
#(
    parameter int PROG_CYCLES = `EEB_PROG_CYCLES
)(
    input  wire logic       clk_sys_i,
    input  wire logic       resetn_i,
    eeb_if.slave            bus,
    input  wire logic       chip_select_strap_high_i,
    input  wire logic       chip_select_strap_mid_i,
    input  wire logic       chip_select_strap_low_i,
    output logic            standby_o,
    output logic            busy_o,
    output logic [11:0]     word_addr_o,
    output logic [7:0]      wr_data_o
);
    initial
    begin
        if (PROG_CYCLES < 1)
            $error("PROG_CYCLES must be at least one");
    end

    localparam int ROWS = `EEB_ROWS;
    localparam int ROWB = `EEB_ROW_BYTES;
    localparam int CNT_W = $clog2(PROG_CYCLES + 1);

    logic [7:0]       mem_r [ROWS*ROWB];
    logic [1:0]       scl_s_r;
    logic [1:0]       sda_s_r;
    logic             scl_d_r;
    logic             sda_d_r;
    logic [5:0]       strap_s_r;
    eeb_state_e       st_r;
    logic [2:0]       bit_r;
    logic             in_ack_r;
    logic [7:0]       sh_r;
    logic             ack_drv_r;
    logic             out_drv_r;
    logic             out_bit_r;
    logic [11:0]      addr_r;
    logic [7:0]       data_r;
    logic [7:0]       rd_r;
    logic             rd_mode_r;
    logic [CNT_W-1:0] prog_cnt_r;

    wire scl   = scl_s_r[1];
    wire sda   = sda_s_r[1];
    wire rise  = scl && !scl_d_r;
    wire fall  = !scl && scl_d_r;
    wire start = scl && scl_d_r && sda_d_r && !sda;
    wire stop  = scl && scl_d_r && !sda_d_r && sda;
    wire [7:0] byte_in = {sh_r[6:0], sda};
    wire last_bit = (bit_r == `EEB_BIT_LAST);

    // Device address match against type code and straps
    function automatic logic addr_hit(input logic [7:0] b, input logic [2:0] s);
        addr_hit = (b[`EEB_TYPE_MSB:`EEB_TYPE_LSB] == `EEB_TYPE_ID)
                && (b[`EEB_STRAP_MSB:`EEB_STRAP_LSB] == s);
    endfunction : addr_hit

    // Two-flop synchronisers on the pins, then one delay for edges
    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i)
        begin
            scl_s_r <= 2'h3;
            sda_s_r <= 2'h3;
            scl_d_r <= 1'h1;
            sda_d_r <= 1'h1;
        end
        else
        begin
            scl_s_r <= {scl_s_r[0], bus.scl_i};
            sda_s_r <= {sda_s_r[0], bus.sda_i};
            scl_d_r <= scl;
            sda_d_r <= sda;
        end
    end

    // Straps are pins: two flops before the address compare reads them
    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i)
            strap_s_r <= 6'h00;
        else
            strap_s_r <= {strap_s_r[2:0], chip_select_strap_high_i, chip_select_strap_mid_i,
                          chip_select_strap_low_i};
    end

    // Protocol engine; programming locks it out entirely
    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i)
        begin
            st_r       <= EEB_ST_IDLE;
            bit_r      <= 3'h0;
            in_ack_r   <= 1'b0;
            sh_r       <= 8'h00;
            ack_drv_r  <= 1'b0;
            out_drv_r  <= 1'b0;
            out_bit_r  <= 1'b1;
            addr_r     <= 12'h000;
            data_r     <= 8'h00;
            rd_r       <= 8'h00;
            rd_mode_r  <= 1'b0;
            prog_cnt_r <= '0;
        end
        else if (st_r == EEB_ST_PROG)
        begin
            ack_drv_r <= 1'b0;
            out_drv_r <= 1'b0;
            if (prog_cnt_r == CNT_W'(PROG_CYCLES - 1))
            begin
                st_r       <= EEB_ST_IDLE;
                prog_cnt_r <= '0;
            end
            else
                prog_cnt_r <= prog_cnt_r + 1'b1;
        end
        else if (start)
        begin
            st_r      <= EEB_ST_DEV;
            bit_r     <= 3'h0;
            in_ack_r  <= 1'b1;  // First fall after Start precedes bit one, like an ack end
            ack_drv_r <= 1'b0;
            out_drv_r <= 1'b0;
        end
        else if (stop)
        begin
            ack_drv_r <= 1'b0;
            out_drv_r <= 1'b0;
            // Only a completed data byte launches programming
            if (st_r == EEB_ST_WAIT && !rd_mode_r)
                st_r <= EEB_ST_PROG;
            else
                st_r <= EEB_ST_IDLE;
        end
        else if (st_r != EEB_ST_IDLE)
        begin
            if (rise && !in_ack_r)
            begin
                sh_r <= byte_in;
            end
            if (rise && in_ack_r && st_r == EEB_ST_SEND && sda)
                st_r <= EEB_ST_IDLE;
            if (fall)
            begin
                if (in_ack_r)
                begin
                    // End of ninth clock: release and resume
                    in_ack_r  <= 1'b0;
                    ack_drv_r <= 1'b0;
                    bit_r     <= 3'h0;
                    if (st_r == EEB_ST_SEND)
                    begin
                        out_drv_r <= 1'b1;
                        out_bit_r <= rd_r[7];
                        rd_r      <= {rd_r[6:0], 1'b1};
                    end
                    else
                        out_drv_r <= 1'b0;
                end
                else if (last_bit)
                begin
                    in_ack_r  <= 1'b1;
                    out_drv_r <= 1'b0;
                    ack_drv_r <= 1'b0;
                    case (st_r)
                        EEB_ST_DEV:
                        begin
                            if (addr_hit(sh_r, strap_s_r[5:3]))
                            begin
                                ack_drv_r <= 1'b1;
                                rd_mode_r <= sh_r[`EEB_DIR_BIT];
                                if (sh_r[`EEB_DIR_BIT])
                                begin
                                    st_r <= EEB_ST_SEND;
                                    rd_r <= mem_r[addr_r];
                                end
                                else
                                    st_r <= EEB_ST_AHI;
                            end
                            else
                                st_r <= EEB_ST_IDLE;
                        end
                        EEB_ST_AHI:
                        begin
                            addr_r[11:8] <= sh_r[`EEB_ADDR_HI_MSB:0];
                            ack_drv_r    <= 1'b1;
                            st_r         <= EEB_ST_ALO;
                        end
                        EEB_ST_ALO:
                        begin
                            addr_r[7:0] <= sh_r;
                            ack_drv_r   <= 1'b1;
                            st_r        <= EEB_ST_DATA;
                        end
                        EEB_ST_DATA:
                        begin
                            data_r    <= sh_r;
                            ack_drv_r <= 1'b1;
                            st_r      <= EEB_ST_WAIT;
                        end
                        EEB_ST_SEND:
                        begin
                            // Byte sent: current address advances before the master answers in the ninth clock
                            addr_r <= addr_r + 12'h001;
                        end
                        default:
                            st_r <= EEB_ST_IDLE;  // Extra bytes unsupported
                    endcase
                end
                else
                begin
                    bit_r <= bit_r + 3'h1;
                    if (st_r == EEB_ST_SEND && out_drv_r)
                    begin
                        out_bit_r <= rd_r[7];
                        rd_r      <= {rd_r[6:0], 1'b1};
                    end
                end
            end
        end
    end

    // Array write lands on the first programming cycle
    always_ff @(posedge clk_sys_i)
    begin
        if (st_r == EEB_ST_PROG && prog_cnt_r == '0)
            mem_r[addr_r] <= data_r;
    end

    // Open-drain drive: oe_n low only when pulling low
    always_comb
    begin
        bus.sda_s_o    = 1'b0;
        bus.sda_s_oe_n = !(ack_drv_r || (out_drv_r && !out_bit_r));
    end

    assign standby_o   = (st_r == EEB_ST_IDLE);
    assign busy_o      = (st_r == EEB_ST_PROG);
    assign word_addr_o = addr_r;
    assign wr_data_o   = data_r;
endmodule : eeb_slave
`default_nettype wire

// File: tb/eeb_link_asserts.sv
// Concurrent checks on the two-wire link between memory slave and bus master
`timescale 1ns/1ps
`default_nettype none
module eeb_link_asserts #(
    parameter logic [7:0] HALF_DIV = 8'h0A
)(
    input  wire logic clk_sys_i,
    input  wire logic resetn_i,
    input  wire logic scl_i,
    input  wire logic sda_i,
    input  wire logic scl_o,
    input  wire logic scl_oe_n,
    input  wire logic sda_m_o,
    input  wire logic sda_m_oe_n,
    input  wire logic sda_s_o,
    input  wire logic sda_s_oe_n
);
    localparam int REL_MAX = 2 * HALF_DIV;  // One link clock low phase
    logic       scl_q_r, sda_q_r, in_frame_r, rd_r;
    logic [3:0] bit_cnt_r, low_falls_r;
    logic [2:0] byte_cnt_r;
    wire s_low_w = !sda_s_oe_n && !sda_s_o;
    wire m_low_w = !sda_m_oe_n && !sda_m_o;
    wire start_w = scl_i && scl_q_r && sda_q_r && !sda_i;
    wire stop_w  = scl_i && scl_q_r && !sda_q_r && sda_i;
    wire rise_w  = scl_i && !scl_q_r;
    wire fall_w  = !scl_i && scl_q_r;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);
    // Previous line levels, for edge and condition detection
    always_ff @(posedge clk_sys_i)
    begin
        scl_q_r <= scl_i;
        sda_q_r <= sda_i;
    end
    // Frame lasts from a Start to a Stop
    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i || stop_w)
            in_frame_r <= 1'b0;
        else if (start_w)
            in_frame_r <= 1'b1;
    end
    // Bit position 1..9 in the byte and byte count since Start
    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i || start_w)
        begin
            bit_cnt_r  <= 4'h0;
            byte_cnt_r <= 3'h0;
        end
        else if (rise_w && in_frame_r)
        begin
            bit_cnt_r <= (bit_cnt_r == 4'h9) ? 4'h1 : bit_cnt_r + 4'h1;
            if (bit_cnt_r == 4'h9 && byte_cnt_r != 3'h7)
                byte_cnt_r <= byte_cnt_r + 3'h1;
        end
    end
    // Direction bit is the eighth bit of the first byte
    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i)
            rd_r <= 1'b0;
        else if (rise_w && in_frame_r && byte_cnt_r == 3'h0 && bit_cnt_r == 4'h7)
            rd_r <= sda_i;
    end
    // Clock falls seen while the slave keeps the line low; a stuck slave overruns it
    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i || !s_low_w)
            low_falls_r <= 4'h0;
        else if (fall_w && low_falls_r != 4'hF)
            low_falls_r <= low_falls_r + 4'h1;
    end
    AST_RELEASED_AFTER_RESET: assert property ($rose(resetn_i) |-> sda_s_oe_n)
        else $error("slave drives data line after reset");
    AST_DRIVE_CHANGE_SCL_LOW: assert property ($changed(s_low_w) |-> !scl_i)
        else $error("slave changed data line while clock high");
    AST_ACK_SENDER_FREE: assert property (
        scl_i && bit_cnt_r == 4'h9 && s_low_w |-> !m_low_w)
        else $error("master still drives during slave acknowledge");
    AST_SLAVE_SILENT_RX: assert property (scl_i && scl_q_r && in_frame_r && bit_cnt_r != 4'h9
        && bit_cnt_r != 4'h0 && (byte_cnt_r == 3'h0 || !rd_r) |-> !s_low_w)
        else $error("slave drives during bits it receives");
    AST_NACK_RELEASE: assert property (fall_w && bit_cnt_r == 4'h9 && byte_cnt_r != 3'h0
        && rd_r && sda_q_r |-> !s_low_w [*8])
        else $error("slave drives after master no-acknowledge");
    AST_ACK_RELEASE: assert property (
        fall_w && bit_cnt_r == 4'h9 && !rd_r |-> ##[0:REL_MAX] !s_low_w)
        else $error("slave kept acknowledge past ninth clock");
    AST_RELEASE_WITHIN_NINE: assert property (s_low_w |-> low_falls_r <= 4'h9)
        else $error("slave held data line over nine clocks");
    AST_SILENT_OUTSIDE_FRAME: assert property (!in_frame_r |-> !s_low_w)
        else $error("slave drives without a Start");
    COV_WRITE_ACK: cover property (scl_i && bit_cnt_r == 4'h9 && !rd_r && s_low_w);
    COV_READ_NACK: cover property (fall_w && bit_cnt_r == 4'h9 && rd_r && sda_q_r);
    COV_STOP: cover property (stop_w);
endmodule : eeb_link_asserts
`default_nettype wire

// File: tb/eeb_slave_test.sv
// Self-checking bench: memory slave and bus master joined across the link
`timescale 1ns/1ps
`default_nettype none
module eeb_slave_test;
    localparam int         PROG = 600;    // Short programming, still outlasts a refused frame
    localparam logic [7:0] HALF = 8'h05;  // 20 clocks a bit, an 80 ns link clock
    logic        clk, rst_s_n, rst_m_n, wr_req, rd_req, rec_req;
    logic [2:0]  strap_req, strap_pin;
    logic [11:0] addr_req, word_addr;
    logic [7:0]  data_req, wr_data, rd_data;
    logic        standby, busy, ready, done, nack;
    int          err_total, checks, m_addr, m_data;
    int          cyc = 0;
    int          m_cur = 0;     // Model of the slave's current address
    int          m_mem [int];   // Model of the array bytes written so far
    eeb_if link_if ();
    eeb_slave #(.PROG_CYCLES(PROG)) eeb_slave_inst (.clk_sys_i(clk), .resetn_i(rst_s_n),
        .bus(link_if), .chip_select_strap_high_i(strap_pin[2]),
        .chip_select_strap_mid_i(strap_pin[1]), .chip_select_strap_low_i(strap_pin[0]),
        .standby_o(standby), .busy_o(busy), .word_addr_o(word_addr), .wr_data_o(wr_data));
    eeb_master #(.HALF_DIV(HALF)) eeb_master_inst (.clk_sys_i(clk), .resetn_i(rst_m_n),
        .bus(link_if), .wr_req_i(wr_req), .rd_req_i(rd_req), .recover_req_i(rec_req),
        .strap_i(strap_req), .addr_i(addr_req), .data_i(data_req), .ready_o(ready),
        .done_o(done), .nack_o(nack), .rd_data_o(rd_data));
    eeb_link_asserts #(.HALF_DIV(HALF)) eeb_link_asserts_inst (.clk_sys_i(clk),
        .resetn_i(rst_s_n), .scl_i(link_if.scl_i), .sda_i(link_if.sda_i),
        .scl_o(link_if.scl_o), .scl_oe_n(link_if.scl_oe_n), .sda_m_o(link_if.sda_m_o),
        .sda_m_oe_n(link_if.sda_m_oe_n), .sda_s_o(link_if.sda_s_o),
        .sda_s_oe_n(link_if.sda_s_oe_n));
    // System clock and a cycle count for timing the programming cycle
    initial clk = 1'b0;
    always #2 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    task automatic summarize;
        if (err_total == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : summarize
    task automatic chk_flag(input string what, input logic exp, input logic got);
        checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_flag
    task automatic chk_word(input string what, input logic [11:0] exp, input logic [11:0] got);
        checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_word
    // Bounded wait; running out ends the run as a failure
    task automatic wait_level(ref logic sig, input logic lvl, input int lim);
        int n;
        n = 0;
        while (sig !== lvl)
        begin
            @(posedge clk);
            n++;
            if (n > lim)
            begin
                err_total++;
                $display("MISMATCH wait expected %b seen %b", lvl, sig);
                summarize();
            end
        end
    endtask : wait_level
    // One master request, held for the edge at which ready is sampled
    task automatic xfer(input int k, input logic [2:0] s, input logic [11:0] a,
                        input logic [7:0] d);
        wait_level(ready, 1'b1, 100);
        wr_req    <= (k == 0);
        rd_req    <= (k == 1);
        rec_req   <= (k == 2);
        strap_req <= s;
        addr_req  <= a;
        data_req  <= d;
        @(posedge clk);
        wr_req  <= 1'b0;
        rd_req  <= 1'b0;
        rec_req <= 1'b0;
        wait_level(done, 1'b1, 3000);
    endtask : xfer
    // Model predicts acknowledge, capture and programming; probe writes while busy
    task automatic run(input int k, input logic [2:0] s, input logic [11:0] a,
                       input logic [7:0] d, input bit probe);
        logic exp_nack;
        int   rise_c;
        exp_nack = (s !== strap_pin);
        xfer(k, s, a, d);
        chk_flag("nack", exp_nack, nack);
        if (k == 1 || exp_nack)
        begin
            if (!exp_nack)
            begin
                chk_word("rd_data", 12'(m_mem[m_cur]), {4'h0, rd_data});
                m_cur = 12'(m_cur + 1);
            end
            wait_level(standby, 1'b1, 20);
            chk_flag("busy_idle", 1'b0, busy);
            chk_flag("sda_free", 1'b1, link_if.sda_i);
            return;
        end
        m_addr = a;
        m_data = d;
        m_mem[m_addr] = m_data;
        m_cur = m_addr;
        chk_word("word_addr", 12'(m_addr), word_addr);
        chk_word("wr_data", 12'(m_data), {4'h0, wr_data});
        wait_level(busy, 1'b1, 20);
        rise_c = cyc;
        chk_flag("standby_prog", 1'b0, standby);
        if (probe)
        begin
            xfer(0, strap_pin, ~a, ~d);
            chk_flag("busy_nack", 1'b1, nack);
            chk_word("busy_addr", 12'(m_addr), word_addr);
        end
        wait_level(busy, 1'b0, PROG + 10);
        chk_flag("prog_len", 1'b1, cyc - rise_c >= PROG - 1 && cyc - rise_c <= PROG + 1);
        wait_level(standby, 1'b1, 4);
        chk_flag("standby_done", 1'b1, standby);
    endtask : run
    // Main sequence
    initial
    begin
        void'($urandom(32'h33eda248));
        {rst_s_n, rst_m_n, wr_req, rd_req, rec_req} = 5'h00;
        {strap_req, strap_pin, addr_req, data_req} = 26'h0;
        err_total = 0;
        checks = 0;
        @(posedge clk);
        @(posedge clk);
        chk_flag("standby_rst", 1'b1, standby);
        chk_flag("busy_rst", 1'b0, busy);
        rst_s_n   <= 1'b1;
        rst_m_n   <= 1'b1;
        strap_pin <= 3'($urandom_range(7, 0));
        @(posedge clk);
        for (int i = 0; i < 3; i++)
            // Top address last, so later reads wrap onto a written location
            run(0, strap_pin, (i == 0) ? 12'h000 : (i == 2) ? 12'hFFF : 12'($urandom),
                8'($urandom), i == 1);
        for (int k = 0; k < 8; k++)
            if (3'(k) != strap_pin)
                run(k % 2, 3'(k), 12'($urandom), 8'($urandom), 1'b0);
        run(1, strap_pin, 12'h000, 8'h00, 1'b0);
        // Master reset inside the read data byte leaves the slave mid-byte
        wait_level(ready, 1'b1, 100);
        rd_req    <= 1'b1;
        strap_req <= strap_pin;
        @(posedge clk);
        rd_req <= 1'b0;
        repeat (300) @(posedge clk);
        rst_m_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_m_n <= 1'b1;
        xfer(2, strap_pin, 12'h000, 8'h00);
        chk_flag("recover_nack", 1'b0, nack);
        chk_flag("recover_sda", 1'b1, link_if.sda_i);
        run(0, strap_pin, 12'h000, 8'($urandom), 1'b0);
        summarize();
    end
endmodule : eeb_slave_test
`default_nettype wire
